// file: dv/cid_ctrl_props.sv
// port-level assertion checker for the caller id control block
module cid_ctrl_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [3:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        demod_in_i,
    input wire logic        demod_output_pin_o,
    input wire logic [2:0]  mode_select_lines_o,
    input wire logic [3:0]  digit_o,
    input wire logic        tone_enable_strobe_o,
    input wire logic        mute_output_o,
    input wire logic        mute_output_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic wr_dial;
    logic unmapped;
    // a full-word write to control while already in dialing mode
    assign wr_dial = ack_o && we_i && adr_i == cid_pkg::ctrl_addr
        && sel_i == 4'hF && dat_i[2:0] == cid_pkg::mode_dtmf
        && mode_select_lines_o == cid_pkg::mode_dtmf;
    assign unmapped = adr_i != cid_pkg::ctrl_addr
        && adr_i != cid_pkg::status_addr && adr_i != cid_pkg::rxdata_addr;
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered in one cycle");
    a_unmapped_zero: assert property (ack_o && !we_i && unmapped
        |-> dat_o == 32'h0) else $error("unmapped read not zero");
    a_pd_idle: assert property (
        mode_select_lines_o == cid_pkg::mode_power_down
        && $past(mode_select_lines_o) == cid_pkg::mode_power_down
        |-> demod_output_pin_o) else $error("output not high in power down");
    a_fsk_copy: assert property (
        mode_select_lines_o == cid_pkg::mode_fsk
        && $past(mode_select_lines_o) == cid_pkg::mode_fsk
        |-> demod_output_pin_o == $past(demod_in_i))
        else $error("demodulated stream not passed on");
    a_tone_mode: assert property ($rose(tone_enable_strobe_o)
        |-> mode_select_lines_o == cid_pkg::mode_dtmf)
        else $error("tone started outside dialing mode");
    a_tone_on: assert property (wr_dial && dat_i[8]
        |-> ##[1:3] tone_enable_strobe_o) else $error("tone not started");
    a_tone_off: assert property (wr_dial && !dat_i[8]
        |-> ##[1:3] !tone_enable_strobe_o) else $error("tone not stopped");
    a_digit_hold: assert property (tone_enable_strobe_o
        && $past(tone_enable_strobe_o) |-> $stable(digit_o))
        else $error("digit changed during tone");
    a_mute_follow: assert property (
        mute_output_oe_o == tone_enable_strobe_o && !mute_output_o)
        else $error("mute drive not tied to tone");
endmodule : cid_ctrl_props

bind cid_ctrl cid_ctrl_props i_cid_ctrl_props (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .demod_in_i(demod_in_i),
    .demod_output_pin_o(demod_output_pin_o),
    .mode_select_lines_o(mode_select_lines_o), .digit_o(digit_o),
    .tone_enable_strobe_o(tone_enable_strobe_o),
    .mute_output_o(mute_output_o), .mute_output_oe_o(mute_output_oe_o));

// file: dv/fsk_source.sv
// character source standing in for the demodulator output
module fsk_source #(
    parameter int bit_cycles = 16
) (
    input  wire logic clk_i,
    output logic      line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line_o = 1'b1;
    task automatic send(input logic [7:0] b, input logic bad_stop);
        logic [9:0] f;
        // zero start, lsb first, one stop
        f = {~bad_stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            line_o <= f[i];
            repeat (bit_cycles - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        line_o <= 1'b1;
        repeat (2 * bit_cycles) @(posedge clk_i);
    endtask : send
endmodule : fsk_source

// file: dv/testbench.sv
// self-checking bench for the caller id control block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int bc = 16;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [3:0]  sel = 4'hF;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        ack, line, dout, tone, mute, mute_oe;
    logic [2:0]  mode;
    logic [3:0]  digit;
    int          fails = 0;
    int          checks = 0;
    int          seed = 32'h84811BB5;
    always #10 clk = ~clk;
    fsk_source #(.bit_cycles(bc)) i_fsk_source (.clk_i(clk), .line_o(line));
    cid_ctrl #(.bit_cycles(bc)) i_cid_ctrl (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
        .demod_in_i(line), .demod_output_pin_o(dout),
        .mode_select_lines_o(mode), .digit_o(digit),
        .tone_enable_strobe_o(tone), .mute_output_o(mute),
        .mute_output_oe_o(mute_oe));
    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        checks++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // no fixed latency assumed: wait for ack, bounded
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            fails++;
            complete_run();
        end
        @(posedge clk);
    endtask : wb
    task automatic wait_bit(input int b);
        int n;
        n = 0;
        do begin
            wb(1'b0, cid_pkg::status_addr, 32'h0);
            n++;
        end while (q[b] !== 1'b1 && n < 400);
        if (q[b] !== 1'b1) begin
            fails++;
            complete_run();
        end
    endtask : wait_bit
    function automatic logic [7:0] csum(input logic [7:0] b[$]);
        logic [7:0] s;
        s = 8'h00;
        foreach (b[i]) s = s + b[i];
        return 8'h00 - s;
    endfunction : csum
    task automatic msg(input int len, input logic bad);
        logic [7:0] b[$];
        b.push_back(8'($random(seed)));
        b.push_back(len[7:0]);
        repeat (len) b.push_back(8'($random(seed)));
        b.push_back(csum(b) + {7'h0, bad});
        foreach (b[i]) begin
            i_fsk_source.send(b[i], 1'b0);
            wait_bit(cid_pkg::st_valid_bit);
            wb(1'b0, cid_pkg::rxdata_addr, 32'h0);
            chk("rx char", {24'h0, b[i]}, {24'h0, q[7:0]});
        end
        wb(1'b0, cid_pkg::status_addr, 32'h0);
        chk("done err", {30'h0, bad, 1'b1}, {30'h0, q[2:1]});
        wb(1'b1, cid_pkg::ctrl_addr, 32'h201);
    endtask : msg
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("pd pins", 32'hF, {28'h0, mode, dout});
        wb(1'b0, 4'hC, 32'h0);
        chk("unmapped", 32'h0, q);
        wb(1'b1, cid_pkg::ctrl_addr, 32'h1);
        wb(1'b0, cid_pkg::ctrl_addr, 32'h0);
        chk("fsk mode", 32'h1, {29'h0, mode});
        msg(9, 1'b0);
        msg(18, 1'b0);
        msg(1 + ($random(seed) & 31), 1'b0);
        msg(0, 1'b0);
        msg(3, 1'b1);
        i_fsk_source.send(8'hA5, 1'b1);
        wait_bit(cid_pkg::st_frame_bit);
        wb(1'b1, cid_pkg::ctrl_addr, 32'h201);
        wb(1'b0, cid_pkg::status_addr, 32'h0);
        chk("cleared", 32'h0, {29'h0, q[3:1]});
        wb(1'b1, cid_pkg::ctrl_addr, 32'h104);
        wb(1'b0, cid_pkg::ctrl_addr, 32'h0);
        chk("alert", 32'h8, {28'h0, mode, tone});
        wb(1'b1, cid_pkg::ctrl_addr, 32'h0);
        for (int d = 0; d < 16; d++) begin
            wb(1'b1, cid_pkg::ctrl_addr, {23'h0, 1'b1, d[3:0], 4'h0});
            repeat (2) @(posedge clk);
            chk("digit", {28'h0, d[3:0]}, {28'h0, digit});
            chk("mute on", 32'h2, {30'h0, mute_oe, mute});
            wb(1'b0, cid_pkg::status_addr, 32'h0);
            chk("tone st", 32'h3, {30'h0, q[5:4]});
            wb(1'b1, cid_pkg::ctrl_addr, {24'h0, d[3:0], 4'h0});
            repeat (2) @(posedge clk);
            chk("tone off", 32'h0, {30'h0, tone, mute_oe});
        end
        wb(1'b1, cid_pkg::ctrl_addr, 32'h7);
        repeat (2) @(posedge clk);
        chk("pd end", 32'hF, {28'h0, mode, dout});
        complete_run();
    end
endmodule : testbench

// file: logic/char_rx.sv
// start-stop character receiver for the demodulated stream
module char_rx #(
    parameter int bit_cycles = cid_pkg::bit_cycles
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       enable_i,
    input  wire logic       serial_i,
    output logic [7:0]      data_o,
    output logic            valid_o,
    output logic            frame_err_o
);
    localparam int half = bit_cycles / 2;

    typedef enum logic [1:0] {idle_type, start_type, bits_type, stop_type}
        rx_state_type;

    rx_state_type state;
    logic [15:0]  cnt;
    logic [2:0]   idx;
    logic [7:0]   shift;

    // ------------------------------------------------------------
    // mid-bit sampling state machine
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        valid_o     <= 1'b0;
        frame_err_o <= 1'b0;
        if (rst_i || !enable_i) begin
            state <= idle_type;
            cnt   <= 16'h0000;
            idx   <= 3'h0;
            shift <= 8'h00;
            data_o <= 8'h00;
        end else begin
            unique case (state)
                idle_type: begin
                    cnt <= 16'h0000;
                    if (!serial_i) begin
                        state <= start_type;
                    end
                end
                start_type: begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == 16'(half)) begin
                        cnt   <= 16'h0000;
                        idx   <= 3'h0;
                        // a glitch shorter than half a bit is no start
                        state <= serial_i ? idle_type : bits_type;
                    end
                end
                bits_type: begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == 16'(bit_cycles - 1)) begin
                        cnt   <= 16'h0000;
                        shift <= {serial_i, shift[7:1]};
                        idx   <= idx + 3'h1;
                        if (idx == 3'h7) begin
                            state <= stop_type;
                        end
                    end
                end
                stop_type: begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == 16'(bit_cycles - 1)) begin
                        data_o      <= shift;
                        valid_o     <= serial_i;
                        frame_err_o <= !serial_i;
                        state       <= idle_type;
                    end
                end
            endcase
        end
    end

endmodule : char_rx

// file: logic/cid_ctrl.sv
// caller id receiver and dialer control with wishbone registers
module cid_ctrl #(
    parameter int bit_cycles = cid_pkg::bit_cycles
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        demod_in_i,
    output logic             demod_output_pin_o,
    output logic [2:0]       mode_select_lines_o,
    output logic [3:0]       digit_o,
    output logic             tone_enable_strobe_o,
    output logic             mute_output_o,
    output logic             mute_output_oe_o
);
    logic [2:0] mode;
    logic [3:0] digit;
    logic       tone_req;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic       rx_ferr;
    logic [7:0] last_char;
    logic       char_valid;
    logic       msg_done;
    logic       sum_err;
    logic       frame_err;
    logic [7:0] sum;
    logic [7:0] remain;
    logic       fsk_mode;
    logic       wr;
    logic       rd;
    logic       tone_active;
    logic       mute_oe;
    logic [3:0] digit_latch;
    logic       dtmf_mode;
    logic       rd_rxdata;
    logic       clear_req;
    logic       sum_word;
    logic       sum_bad;
    cid_pkg::msg_state_type mstate;

    assign fsk_mode = (mode == cid_pkg::mode_fsk);
    // dtmf generator and call progress on 000
    assign dtmf_mode = (mode == cid_pkg::mode_dtmf);
    assign wr = cyc_i && stb_i && we_i && !ack_o;
    assign rd = cyc_i && stb_i && !we_i && !ack_o;

    // ------------------------------------------------------------
    // wishbone slave: one wait state, ack for one cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode     <= cid_pkg::mode_reset;
            digit    <= 4'h0;
            tone_req <= 1'b0;
        end else if (wr && adr_i == cid_pkg::ctrl_addr) begin
            if (sel_i[0]) begin
                mode  <= dat_i[cid_pkg::mode_lsb +: 3];
                digit <= dat_i[cid_pkg::digit_lsb +: 4];
            end
            if (sel_i[1]) begin
                tone_req <= dat_i[cid_pkg::tone_bit];
            end
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (rd) begin
            unique case (adr_i)
                cid_pkg::ctrl_addr:
                    dat_o <= {23'h000000, tone_req, digit, 1'b0, mode};
                cid_pkg::status_addr:
                    dat_o <= {24'h000000, 2'h0, tone_active, mute_oe,
                              frame_err, sum_err, msg_done, char_valid};
                cid_pkg::rxdata_addr:
                    dat_o <= {24'h000000, last_char};
                default:
                    dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // demodulated stream and character receiver
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            demod_output_pin_o <= 1'b1;
        end else begin
            // stream shown in every mode but power down
            demod_output_pin_o <= (mode == cid_pkg::mode_power_down)
                                  ? 1'b1 : demod_in_i;
        end
    end

    char_rx #(
        .bit_cycles (bit_cycles)
    ) u_rx (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .enable_i    (fsk_mode),
        .serial_i    (demod_in_i),
        .data_o      (rx_data),
        .valid_o     (rx_valid),
        .frame_err_o (rx_ferr)
    );

    // ------------------------------------------------------------
    // bus strobes that touch the receive flags
    // ------------------------------------------------------------
    assign rd_rxdata = rd && adr_i == cid_pkg::rxdata_addr;
    // a clear rides on a control write with sel[1] set
    assign clear_req = wr && adr_i == cid_pkg::ctrl_addr && sel_i[1]
                       && dat_i[cid_pkg::clear_bit];

    // ------------------------------------------------------------
    // last character; a new one beats the read that clears valid
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || !fsk_mode) begin
            last_char  <= 8'h00;
            char_valid <= 1'b0;
        end else if (rx_valid) begin
            last_char  <= rx_data;
            char_valid <= 1'b1;
        end else if (rd_rxdata) begin
            char_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // framing error; a bad stop bit beats a clear in one cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || !fsk_mode) begin
            frame_err <= 1'b0;
        end else if (rx_ferr) begin
            frame_err <= 1'b1;
        end else if (clear_req) begin
            frame_err <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // message walk: type, length, data words, checksum
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        // leaving receive mode drops a half-read message
        if (rst_i || !fsk_mode) begin
            mstate <= cid_pkg::msg_type_type;
            sum    <= 8'h00;
            remain <= 8'h00;
        end else if (rx_valid) begin
            unique case (mstate)
                cid_pkg::msg_type_type: begin
                    sum    <= rx_data;
                    mstate <= cid_pkg::msg_len_type;
                end
                cid_pkg::msg_len_type: begin
                    sum    <= sum + rx_data;
                    remain <= rx_data;
                    mstate <= (rx_data == 8'h00)
                              ? cid_pkg::msg_sum_type
                              : cid_pkg::msg_data_type;
                end
                cid_pkg::msg_data_type: begin
                    sum    <= sum + rx_data;
                    remain <= remain - 8'h01;
                    if (remain == 8'h01) begin
                        mstate <= cid_pkg::msg_sum_type;
                    end
                end
                cid_pkg::msg_sum_type: begin
                    // the checksum word is judged in the flag block
                    mstate <= cid_pkg::msg_type_type;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // done and checksum flags, raised by the checksum word
    // ------------------------------------------------------------
    assign sum_word = rx_valid && mstate == cid_pkg::msg_sum_type;
    assign sum_bad  = 8'(sum + rx_data) != 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i || !fsk_mode) begin
            msg_done <= 1'b0;
            sum_err  <= 1'b0;
        end else if (sum_word) begin
            // the event wins over a clear in the same cycle
            msg_done <= 1'b1;
            sum_err  <= (sum_err && !clear_req) || sum_bad;
        end else if (clear_req) begin
            msg_done <= 1'b0;
            sum_err  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // dialer
    // ------------------------------------------------------------
    dial_ctrl u_dial (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .dtmf_mode_i   (dtmf_mode),
        .digit_i       (digit),
        .tone_req_i    (tone_req),
        .digit_latch_o (digit_latch),
        .tone_active_o (tone_active),
        .mute_oe_o     (mute_oe)
    );

    // ------------------------------------------------------------
    // mode lines to the analog front end
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // reset leaves the front end powered down
            mode_select_lines_o <= cid_pkg::mode_reset;
        end else begin
            mode_select_lines_o <= mode;
        end
    end

    // ------------------------------------------------------------
    // dialer pins; mute is open drain, so only its enable moves
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            digit_o              <= 4'h0;
            tone_enable_strobe_o <= 1'b0;
            mute_output_o        <= 1'b0;
            mute_output_oe_o     <= 1'b0;
        end else begin
            digit_o              <= digit_latch;
            tone_enable_strobe_o <= tone_active;
            mute_output_o        <= 1'b0;
            mute_output_oe_o     <= mute_oe;
        end
    end

endmodule : cid_ctrl

// file: logic/cid_pkg.sv
// shared constants for the caller id receiver and dialer control block
package cid_pkg;

    // ------------------------------------------------------------
    // wishbone register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] ctrl_addr   = 4'h0;
    localparam logic [3:0] status_addr = 4'h4;
    localparam logic [3:0] rxdata_addr = 4'h8;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int mode_lsb   = 0;
    localparam int digit_lsb  = 4;
    localparam int tone_bit   = 8;
    localparam int clear_bit  = 9;
    localparam logic [2:0] mode_reset = 3'h7;

    // ------------------------------------------------------------
    // mode codes on the mode select lines
    // ------------------------------------------------------------
    localparam logic [2:0] mode_power_down = 3'h7;
    localparam logic [2:0] mode_fsk        = 3'h1;
    localparam logic [2:0] mode_alert      = 3'h4;
    localparam logic [2:0] mode_dtmf       = 3'h0;

    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int st_valid_bit = 0;
    localparam int st_done_bit  = 1;
    localparam int st_err_bit   = 2;
    localparam int st_frame_bit = 3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int clk_hz    = 50_000_000;
    localparam int baud_bps  = 1200;
    localparam int bit_cycles = clk_hz / baud_bps;
    localparam int half_cycles = bit_cycles / 2;

    typedef enum logic [1:0] {
        msg_type_type,
        msg_len_type,
        msg_data_type,
        msg_sum_type
    } msg_state_type;

endpackage : cid_pkg

// file: logic/dial_ctrl.sv
// digit latch, tone enable and mute drive for the dtmf generator
module dial_ctrl (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       dtmf_mode_i,
    input  wire logic [3:0] digit_i,
    input  wire logic       tone_req_i,
    output logic [3:0]      digit_latch_o,
    output logic            tone_active_o,
    output logic            mute_oe_o
);
    // ------------------------------------------------------------
    // in dtmf mode, latch on the rising tone enable and hold tone until it falls
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            digit_latch_o <= 4'h0;
            tone_active_o <= 1'b0;
            mute_oe_o     <= 1'b0;
        end else begin
            if (tone_req_i && !tone_active_o) begin
                digit_latch_o <= digit_i;
            end
            tone_active_o <= tone_req_i && dtmf_mode_i;
            mute_oe_o     <= tone_req_i && dtmf_mode_i;
        end
    end

endmodule : dial_ctrl
